// ==== core/wdr_map.svh ====
// register map, field positions, reset values and bus answers of the watchdog
// assumes a 32-bit register bus with one aligned word per register
`ifndef WDR_MAP_SVH
`define WDR_MAP_SVH

// register indices; byte address is four times the index
`define WDR_IDX_CSR      16'hffc0
`define WDR_IDX_CNT      16'hffc1
`define WDR_IDX_IRQ_STAT 16'hffc2
`define WDR_IDX_IRQ_CLR  16'hffc3
`define WDR_IDX_IRQ_EN   16'hffc4

// control/status field positions
`define WDR_CSR_FLAG     0
`define WDR_CSR_FLAG_WI  1
`define WDR_CSR_RUN      2
`define WDR_CSR_RUN_WI   3
`define WDR_CSR_WE       4

// interrupt status field positions and width
`define WDR_IRQ_OVF      0
`define WDR_IRQ_REFUSED  1
`define WDR_IRQ_BITS     2

// reset values and counter maximum
`define WDR_CNT_RST      8'h00
`define WDR_CNT_MAX      8'hff
`define WDR_IRQ_RST      2'h0

// bus answers
`define WDR_RESP_OKAY    2'h0
`define WDR_RESP_SLVERR  2'h2

`endif

// ==== core/wdr_pkg.sv ====
// types shared by the watchdog core and its register bus slave
// assumes wdr_map.svh is on the include path
`include "wdr_map.svh"

package wdr_pkg;

  typedef logic [7:0] wdr_byte_t;
  typedef logic [`WDR_IRQ_BITS-1:0] wdr_irq_t;

  typedef struct packed {
    wdr_byte_t counter;
    logic      run;
    logic      resetFlag;
    logic      writeEnable;
    logic      sysReset;
    wdr_irq_t  irqStatus;
    wdr_irq_t  irqEnable;
    logic      irq;
  } wdr_core_s;

  typedef struct packed {
    logic        awHeld;
    logic [31:0] awAddr;
    logic        wHeld;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } wdr_axi_s;

endpackage

// ==== core/wdr_axi_slave.sv ====
// axi4-lite slave that turns bus transfers into register strobes
// assumes a reset already synchronised to clk and a core that decodes in the same cycle
`timescale 1ns/1ps
`default_nettype none
`include "wdr_map.svh"

module wdr_axi_slave (
  input  wire logic        clk,
  input  wire logic        rstSyncB,
  input  wire logic        ce,
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             wrReq,
  output logic [31:0]      wrAddr,
  output logic [31:0]      wrData,
  output logic [3:0]       wrStrb,
  input  wire logic        wrOk,
  output logic [31:0]      rdAddr,
  input  wire logic [31:0] rdData,
  input  wire logic        rdOk
);

  wdr_pkg::wdr_axi_s st_r;
  wdr_pkg::wdr_axi_s st_nxt;

  // readies drop with ce so nothing is taken while the block is frozen
  assign awready = ce && !st_r.awHeld;
  assign wready  = ce && !st_r.wHeld;
  assign arready = ce && !st_r.rvalid;
  // one write at a time: the strobe waits until the previous answer is gone
  assign wrReq   = st_r.awHeld && st_r.wHeld && !st_r.bvalid;
  assign wrAddr  = st_r.awAddr;
  assign wrData  = st_r.wData;
  assign wrStrb  = st_r.wStrb;
  assign rdAddr  = araddr;
  assign bvalid  = st_r.bvalid;
  assign bresp   = st_r.bresp;
  assign rvalid  = st_r.rvalid;
  assign rdata   = st_r.rdata;
  assign rresp   = st_r.rresp;

  always_comb begin
    st_nxt = st_r;
    if (awvalid && awready) begin
      st_nxt.awHeld = 1'b1;
      st_nxt.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      st_nxt.wHeld = 1'b1;
      st_nxt.wData = wdata;
      st_nxt.wStrb = wstrb;
    end
    if (st_r.bvalid && bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (wrReq) begin
      st_nxt.awHeld = 1'b0;
      st_nxt.wHeld  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = wrOk ? `WDR_RESP_OKAY : `WDR_RESP_SLVERR;
    end
    if (st_r.rvalid && rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rdData;
      st_nxt.rresp  = rdOk ? `WDR_RESP_OKAY : `WDR_RESP_SLVERR;
    end
  end

  always_ff @(posedge clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

endmodule

`default_nettype wire

// ==== core/wdr_watchdog.sv ====
// watchdog timer with guarded control/status register and overflow reset
// assumes clk at 40 MHz, rst_b straight from the external reset pin,
// and software on an axi4-lite bus
//
// How it works
// (RULE_01) counter counts while run is set
// (RULE_02) run sets only on enabled, uninhibited write
// (RULE_03) run clears on pin reset or guarded write
// (RULE_04) flag inhibit bit always reads as one
// (RULE_05) flag written only with inhibit bit zero
// (RULE_06) overflow sets flag; internal reset spares it
// (RULE_07) flag clears on pin reset or guarded write
// (RULE_08) counter is eight bits, readable and writable
// (RULE_09) wrap from ff to 00 fires internal reset
// (RULE_10) counter loads zero on reset
// (RULE_11) csr at ffc0, counter at next index
// (RULE_12) write-enable bit gates both guarded writes
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "wdr_map.svh"

module wdr_watchdog (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             sysReset,
  output logic             watchdogResetFlag,
  output logic             irq
);

  logic [1:0]  rstSync_r;
  logic        rstSyncB;

  wdr_pkg::wdr_core_s st_r;
  wdr_pkg::wdr_core_s st_nxt;

  logic        wrReq;
  logic [31:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0]  wrStrb;
  logic        wrOk;
  logic [31:0] rdAddr;
  logic [31:0] rdData;
  logic        rdOk;

  logic        wrLane0;
  logic        wrCsr;
  logic        wrCnt;
  logic        wrClr;
  logic        wrEn;
  logic        runGate;
  logic        flagGate;
  logic        refused;
  logic        overflow;
  wdr_pkg::wdr_byte_t wrByte;
  wdr_pkg::wdr_irq_t  irqEvents;

  // the pin reset asserts at once and releases two edges later
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync_r <= 2'h0;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end

  assign rstSyncB = rstSync_r[1];

  wdr_axi_slave u_slave (
    .clk      (clk),
    .rstSyncB (rstSyncB),
    .ce       (ce),
    .awaddr   (awaddr),
    .awvalid  (awvalid),
    .awready  (awready),
    .wdata    (wdata),
    .wstrb    (wstrb),
    .wvalid   (wvalid),
    .wready   (wready),
    .bresp    (bresp),
    .bvalid   (bvalid),
    .bready   (bready),
    .araddr   (araddr),
    .arvalid  (arvalid),
    .arready  (arready),
    .rdata    (rdata),
    .rresp    (rresp),
    .rvalid   (rvalid),
    .rready   (rready),
    .wrReq    (wrReq),
    .wrAddr   (wrAddr),
    .wrData   (wrData),
    .wrStrb   (wrStrb),
    .wrOk     (wrOk),
    .rdAddr   (rdAddr),
    .rdData   (rdData),
    .rdOk     (rdOk)
  );

  // word index of a byte address; upper bits must be zero to hit a register
  function automatic logic [15:0] regIndex(input logic [31:0] addr);
    logic [15:0] idx;
    idx = 16'h0000;
    if (addr[31:18] == 14'h0000 && addr[1:0] == 2'h0) begin
      idx = addr[17:2];
    end
    return idx;
  endfunction

  function automatic logic isIndex(input logic [31:0] addr,
                                   input logic [15:0] idx);
    return (addr[31:18] == 14'h0000) && (addr[1:0] == 2'h0) &&
           (regIndex(addr) == idx);
  endfunction

  // csr layout, one byte in bits 7:0 of its word:
  //   bit 0 reset flag, bit 1 its write inhibit (reads one)
  //   bit 2 run, bit 3 its write inhibit (reads one)
  //   bit 4 write enable for both guarded bits, bits 7:5 read zero
  // interrupt words share one layout: bit 0 a wrap, bit 1 a refused
  // guarded write; status is read-only, clear takes ones, enable is plain
  // both inhibit bits read back as one whatever was written
  function automatic wdr_pkg::wdr_byte_t csrView(input wdr_pkg::wdr_core_s s);
    wdr_pkg::wdr_byte_t v;
    v = 8'h00;
    v[`WDR_CSR_FLAG]    = s.resetFlag;
    v[`WDR_CSR_FLAG_WI] = 1'b1; // RULE_04
    v[`WDR_CSR_RUN]     = s.run;
    v[`WDR_CSR_RUN_WI]  = 1'b1;
    v[`WDR_CSR_WE]      = s.writeEnable;
    return v;
  endfunction

  // the words that answer; the status word refuses writes
  function automatic logic isMapped(input logic [31:0] addr,
                                    input logic        forWrite);
    logic hit;
    hit = 1'b0;
    if (addr[31:18] == 14'h0000 && addr[1:0] == 2'h0) begin
      case (regIndex(addr))
        `WDR_IDX_CSR: begin
          hit = 1'b1;
        end
        `WDR_IDX_CNT: begin
          hit = 1'b1;
        end
        `WDR_IDX_IRQ_STAT: begin
          hit = !forWrite;
        end
        `WDR_IDX_IRQ_CLR: begin
          hit = 1'b1;
        end
        `WDR_IDX_IRQ_EN: begin
          hit = 1'b1;
        end
        default: begin
          hit = 1'b0;
        end
      endcase
    end
    return hit;
  endfunction

  // a software load beats the count; the sum wraps through zero
  function automatic wdr_pkg::wdr_byte_t nextCount(input wdr_pkg::wdr_byte_t cur,
                                                   input logic               load,
                                                   input wdr_pkg::wdr_byte_t loadVal,
                                                   input logic               run);
    wdr_pkg::wdr_byte_t n;
    n = cur;
    if (load) begin
      n = loadVal; // RULE_08
    end else if (run) begin
      n = cur + 8'h01; // RULE_01
    end
    return n;
  endfunction

  // only a guarded write moves run; the pin reset clears it elsewhere
  function automatic logic nextRun(input logic cur,
                                   input logic gate,
                                   input logic wrBit);
    logic r;
    r = cur;
    if (gate) begin
      r = wrBit;
    end
    return r;
  endfunction

  // software may only clear the flag; a wrap in the same cycle still sets it
  function automatic logic nextFlag(input logic cur,
                                    input logic gate,
                                    input logic wrBit,
                                    input logic wrap);
    logic f;
    f = cur;
    if (gate && !wrBit) begin
      f = 1'b0;
    end
    if (wrap) begin
      f = 1'b1;
    end
    return f;
  endfunction

  // clear first, then set, so an event in the clearing cycle is kept
  function automatic wdr_pkg::wdr_irq_t nextIrqStatus(input wdr_pkg::wdr_irq_t cur,
                                                      input logic              clr,
                                                      input wdr_pkg::wdr_irq_t clrBits,
                                                      input wdr_pkg::wdr_irq_t events);
    wdr_pkg::wdr_irq_t s;
    s = cur;
    if (clr) begin
      s = cur & ~clrBits;
    end
    return s | events;
  endfunction

  // write decode; only byte lane 0 carries the 8-bit registers
  always_comb begin
    wrLane0 = wrReq && wrStrb[0];
    wrByte  = wrData[7:0];
    wrCsr   = wrLane0 && isIndex(wrAddr, `WDR_IDX_CSR); // RULE_11
    wrCnt   = wrLane0 && isIndex(wrAddr, `WDR_IDX_CNT); // RULE_11
    wrClr   = wrLane0 && isIndex(wrAddr, `WDR_IDX_IRQ_CLR);
    wrEn    = wrLane0 && isIndex(wrAddr, `WDR_IDX_IRQ_EN);
    wrOk    = isMapped(wrAddr, 1'b1);
  end

  // guarded writes take the enable bit as it stood before this write
  always_comb begin
    runGate  = wrCsr && !wrByte[`WDR_CSR_RUN_WI] && st_r.writeEnable;  // RULE_02 RULE_12
    flagGate = wrCsr && !wrByte[`WDR_CSR_FLAG_WI] && st_r.writeEnable; // RULE_05 RULE_12
    refused  = wrCsr && !st_r.writeEnable &&
               (!wrByte[`WDR_CSR_RUN_WI] || !wrByte[`WDR_CSR_FLAG_WI]);
    // a counter write in the same cycle wins over the count and its wrap
    overflow = st_r.run && !wrCnt && (st_r.counter == `WDR_CNT_MAX); // RULE_09
  end

  always_comb begin
    irqEvents = `WDR_IRQ_RST;
    irqEvents[`WDR_IRQ_OVF]     = overflow;
    irqEvents[`WDR_IRQ_REFUSED] = refused;
  end

  always_comb begin
    st_nxt = st_r;

    st_nxt.counter = nextCount(st_r.counter, wrCnt, wrByte, st_r.run); // RULE_01 RULE_08

    // run bit; pin reset clears it through the register reset
    st_nxt.run = nextRun(st_r.run, runGate, wrByte[`WDR_CSR_RUN]); // RULE_02 RULE_03

    // enable bit is an ordinary bit of the same register
    if (wrCsr) begin
      st_nxt.writeEnable = wrByte[`WDR_CSR_WE]; // RULE_12
    end

    st_nxt.resetFlag = nextFlag(st_r.resetFlag, flagGate,
                                wrByte[`WDR_CSR_FLAG], overflow); // RULE_05 RULE_06 RULE_07

    // internal reset is a one-cycle pulse on the wrap
    st_nxt.sysReset = overflow; // RULE_09

    st_nxt.irqStatus = nextIrqStatus(st_r.irqStatus, wrClr,
                                     wrByte[`WDR_IRQ_BITS-1:0], irqEvents);

    if (wrEn) begin
      st_nxt.irqEnable = wrByte[`WDR_IRQ_BITS-1:0];
    end

    st_nxt.irq = |(st_nxt.irqStatus & st_nxt.irqEnable);
  end

  // read mux, sampled by the slave on the address handshake
  always_comb begin
    rdData = 32'h0000_0000;
    rdOk   = isMapped(rdAddr, 1'b0);
    case (regIndex(rdAddr))
      `WDR_IDX_CSR: begin
        rdData[7:0] = csrView(st_r);
      end
      `WDR_IDX_CNT: begin
        rdData[7:0] = st_r.counter; // RULE_08
      end
      `WDR_IDX_IRQ_STAT: begin
        rdData[`WDR_IRQ_BITS-1:0] = st_r.irqStatus;
      end
      `WDR_IDX_IRQ_CLR: begin
        rdData = 32'h0000_0000;
      end
      `WDR_IDX_IRQ_EN: begin
        rdData[`WDR_IRQ_BITS-1:0] = st_r.irqEnable;
      end
      default: begin
        rdOk = 1'b0;
      end
    endcase
    // misaligned or out-of-range addresses fold to index 0, which is unmapped
    if (rdAddr[31:18] != 14'h0000 || rdAddr[1:0] != 2'h0) begin
      rdOk   = 1'b0;
      rdData = 32'h0000_0000;
    end
  end

  // the internal reset leaves this state alone; only the pin reset clears it
  always_ff @(posedge clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      st_r             <= '0;
      st_r.counter     <= `WDR_CNT_RST; // RULE_10
      st_r.run         <= 1'b0;         // RULE_03
      st_r.resetFlag   <= 1'b0;         // RULE_07
      st_r.irqStatus   <= `WDR_IRQ_RST;
      st_r.irqEnable   <= `WDR_IRQ_RST;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign sysReset          = st_r.sysReset;
  assign watchdogResetFlag = st_r.resetFlag;
  assign irq               = st_r.irq;

endmodule

`default_nettype wire

// ==== verif/wdr_watchdog_asserts.sv ====
// port-level assertions for the watchdog top
// assumes binding onto wdr_watchdog, one clock domain, rst_b active low
`timescale 1ns/1ps
`default_nettype none

module wdr_watchdog_asserts (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        ce,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        sysReset,
  input wire logic        watchdogResetFlag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence sWrTaken;
    awvalid && awready && wvalid && wready && !bvalid;
  endsequence
  // flag must survive the cycle after the internal reset pulse
  sequence sWrapOut;
    sysReset && watchdogResetFlag ##1 !sysReset && watchdogResetFlag;
  endsequence

  a_wrap_flag: assert property (sysReset && ce |-> sWrapOut)
    else $error("wrap pulse or flag wrong");
  a_flag_source: assert property ($rose(watchdogResetFlag) |-> sysReset)
    else $error("flag set without wrap");
  a_write_answer: assert property (sWrTaken |-> ##[1:2] bvalid)
    else $error("write answer late");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_b_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  a_r_stands: assert property (rvalid && !rready |=>
    rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped");
  a_read_block: assert property (rvalid |-> !arready)
    else $error("read taken while busy");
  a_b_clears: assert property (bvalid && bready |=> !bvalid)
    else $error("write answer repeated");
  a_r_clears: assert property (rvalid && rready |=> !rvalid)
    else $error("read answer repeated");
endmodule

bind wdr_watchdog wdr_watchdog_asserts u_chk (
  .clk(clk), .rst_b(rst_b), .ce(ce), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
  .sysReset(sysReset), .watchdogResetFlag(watchdogResetFlag)
);
`default_nettype wire

// ==== verif/wdr_watchdog_tb.sv ====
// self-checking bench driving the watchdog over its axi4-lite port
// assumes wdr_map.svh on the include path; checker is bound separately
`timescale 1ns/1ps
`default_nettype none
`include "wdr_map.svh"

module wdr_watchdog_tb;
  logic        clk, rst_b, ce, awvalid, wvalid, bready, arvalid, rready, slow;
  logic        awready, wready, bvalid, arready, rvalid, sysReset, watchdogResetFlag, irq;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  logic [7:0]  rd;
  int          mismatches, cmp_count;

  wdr_watchdog DUT (
    .clk(clk), .rst_b(rst_b), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .sysReset(sysReset), .watchdogResetFlag(watchdogResetFlag), .irq(irq)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [31:0] adr(input logic [15:0] idx);
    return {14'h0, idx, 2'h0};
  endfunction

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chkVal(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: data %h not %h", $time, got, exp);
    end
  endtask

  task automatic chkResp(input logic [1:0] got, input logic [1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: resp %h not %h", $time, got, exp);
    end
  endtask

  task automatic chkBit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: bit %b not %b", $time, got, exp);
    end
  endtask

  // entered just after a rising edge; slow delays bready to stall the answer
  task automatic busWr(input logic [15:0] idx, input logic [7:0] d);
    logic awOk, wOk;
    awOk = 1'b0;
    wOk = 1'b0;
    awaddr <= adr(idx);
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(awOk && wOk)) begin
      @(posedge clk);
      if (awready && !awOk) begin
        awOk = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !wOk) begin
        wOk = 1'b1;
        wvalid <= 1'b0;
      end
    end
    if (slow) repeat (3) @(posedge clk);
    bready <= 1'b1;
    do @(posedge clk); while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic busRd(input logic [15:0] idx);
    araddr <= adr(idx);
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    if (slow) repeat (3) @(posedge clk);
    rready <= 1'b1;
    do @(posedge clk); while (!rvalid);
    rd = rdata[7:0];
    rsp = rresp;
    rready <= 1'b0;
  endtask

  task automatic wrOk(input logic [15:0] idx, input logic [7:0] d);
    busWr(idx, d);
    chkResp(rsp, `WDR_RESP_OKAY);
  endtask

  task automatic rdChk(input logic [15:0] idx, input logic [7:0] exp);
    busRd(idx);
    chkVal(rd, exp);
    chkResp(rsp, `WDR_RESP_OKAY);
  endtask

  // irq is registered from the next status and enable, so it moves with them; two edges of margin
  task automatic irqIs(input logic e);
    repeat (2) @(posedge clk);
    chkBit(irq, e);
  endtask

  task automatic waitWrap;
    int n;
    n = 0;
    while (!sysReset && n < 400) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic doReset;
    rst_b <= 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  task automatic t_reset_values;
    rdChk(`WDR_IDX_CSR, 8'h0a);
    rdChk(`WDR_IDX_CNT, `WDR_CNT_RST);
    chkBit(watchdogResetFlag, 1'b0);
    $display("reset values test ended");
  endtask

  task automatic t_guarded_run;
    logic [7:0] c0;
    wrOk(`WDR_IDX_CSR, 8'h04);
    rdChk(`WDR_IDX_CSR, 8'h0a);
    rdChk(`WDR_IDX_IRQ_STAT, 8'h02);
    wrOk(`WDR_IDX_CSR, 8'h10);
    wrOk(`WDR_IDX_CSR, 8'h1c);
    rdChk(`WDR_IDX_CSR, 8'h1a);
    wrOk(`WDR_IDX_CNT, 8'ha5);
    rdChk(`WDR_IDX_CNT, 8'ha5);
    wrOk(`WDR_IDX_CSR, 8'h14);
    rdChk(`WDR_IDX_CSR, 8'h1e);
    busRd(`WDR_IDX_CNT);
    c0 = rd;
    busRd(`WDR_IDX_CNT);
    chkBit(rd > c0, 1'b1);
    wrOk(`WDR_IDX_CSR, 8'h10);
    rdChk(`WDR_IDX_CSR, 8'h1a);
    busRd(`WDR_IDX_CNT);
    c0 = rd;
    rdChk(`WDR_IDX_CNT, c0);
    $display("guarded run test ended");
  endtask

  task automatic t_wrap_irq;
    wrOk(`WDR_IDX_IRQ_CLR, 8'h03);
    wrOk(`WDR_IDX_IRQ_EN, 8'h01);
    wrOk(`WDR_IDX_CNT, 8'hf0);
    wrOk(`WDR_IDX_CSR, 8'h14);
    waitWrap();
    chkBit(sysReset, 1'b1);
    chkBit(watchdogResetFlag, 1'b1);
    rdChk(`WDR_IDX_CSR, 8'h1f);
    wrOk(`WDR_IDX_CSR, 8'h12);
    rdChk(`WDR_IDX_CSR, 8'h1b);
    rdChk(`WDR_IDX_IRQ_STAT, 8'h01);
    irqIs(1'b1);
    wrOk(`WDR_IDX_IRQ_EN, 8'h00);
    irqIs(1'b0);
    wrOk(`WDR_IDX_IRQ_EN, 8'h01);
    irqIs(1'b1);
    wrOk(`WDR_IDX_IRQ_CLR, 8'h01);
    irqIs(1'b0);
    wrOk(`WDR_IDX_CSR, 8'h10);
    rdChk(`WDR_IDX_CSR, 8'h1a);
    wrOk(`WDR_IDX_CSR, 8'h11);
    rdChk(`WDR_IDX_CSR, 8'h1a);
    $display("wrap and interrupt test ended");
  endtask

  task automatic t_bus_errors;
    slow = 1'b1;
    busRd(16'hffc5);
    chkResp(rsp, `WDR_RESP_SLVERR);
    busWr(`WDR_IDX_IRQ_STAT, 8'h03);
    chkResp(rsp, `WDR_RESP_SLVERR);
    rdChk(`WDR_IDX_IRQ_CLR, 8'h00);
    wrOk(`WDR_IDX_CNT, 8'h5a);
    wstrb <= 4'he;
    wrOk(`WDR_IDX_CNT, 8'h33);
    wstrb <= 4'hf;
    rdChk(`WDR_IDX_CNT, 8'h5a);
    slow = 1'b0;
    $display("bus error test ended");
  endtask

  // two counting edges pass between the reads; the twenty with ce low must not
  task automatic t_clock_enable;
    logic [7:0] c0;
    wrOk(`WDR_IDX_CNT, 8'h10);
    wrOk(`WDR_IDX_CSR, 8'h14);
    busRd(`WDR_IDX_CNT);
    c0 = rd;
    ce <= 1'b0;
    repeat (20) @(posedge clk);
    chkBit(arready, 1'b0);
    ce <= 1'b1;
    busRd(`WDR_IDX_CNT);
    chkVal(rd, c0 + 8'h02);
    wrOk(`WDR_IDX_CSR, 8'h10);
    $display("clock enable test ended");
  endtask

  task automatic t_pin_reset;
    wrOk(`WDR_IDX_CNT, 8'hf8);
    wrOk(`WDR_IDX_CSR, 8'h14);
    waitWrap();
    doReset();
    chkBit(watchdogResetFlag, 1'b0);
    rdChk(`WDR_IDX_CSR, 8'h0a);
    rdChk(`WDR_IDX_CNT, `WDR_CNT_RST);
    $display("pin reset test ended");
  endtask

  // a full run needs a few hundred cycles; this leaves ample margin
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    test_done();
  end

  initial begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready, slow} = '0;
    ce = 1'b1;
    wstrb = 4'hf;
    awaddr = '0;
    wdata = '0;
    araddr = '0;
    mismatches = 0;
    cmp_count = 0;
    doReset();
    t_reset_values();
    t_guarded_run();
    t_wrap_irq();
    t_bus_errors();
    t_clock_enable();
    t_pin_reset();
    test_done();
  end
endmodule
`default_nettype wire
